// ==== core/osa_top.sv ====
// Output signal allocator with its front panel parameter editor and monitor.
`timescale 1ns/10ps
`include "osa_params.svh"

module osa_top #(
    parameter int HOLD_CYCLES = `OSA_HOLD_MS * `OSA_CLK_MHZ * 1000,
    parameter int BLINK_CYCLES = `OSA_BLINK_MS * `OSA_CLK_MHZ * 1000,
    parameter int CNT_W = 28
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic NV_INIT,
    input wire osa_pkg::osa_status_type STATUS_IN,
    input wire osa_pkg::osa_method_type CONTROL_METHOD,
    input wire osa_pkg::osa_keys_type KEYS,
    input wire logic [15:0] REF_VALUE,
    input wire logic [7:0] IN_STATE,
    output wire logic [2:0] SEQ_OUT,
    output osa_pkg::osa_state_type DISP_STATE,
    output logic [15:0] DISP_VALUE,
    output logic [3:0] DISP_BLANK
);
    import osa_pkg::*;

    initial begin
        if (HOLD_CYCLES < 2 || HOLD_CYCLES >= 2 ** CNT_W || BLINK_CYCLES < 1
            || BLINK_CYCLES >= 2 ** CNT_W) begin
            $error("osa_top: timing counts do not fit the counters");
        end
    end

    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_CYCLES - 1);

    osa_state_type state, next_state;
    osa_keys_type key_q;
    logic [CNT_W-1:0] shift_cnt, blink_cnt;
    logic shift_fired, blink_on, load_pending, store_en;
    logic [1:0] pidx, next_pidx, digit, next_digit, midx, next_midx;
    logic [15:0] edit_val, next_edit;
    logic [15:0] stored [4];
    logic [47:0] active_alloc;
    logic [15:0] active_pol;
    logic [15:0] next_value, mon_value;
    logic [3:0] next_blank;
    osa_status_type gated;

    // Key edges and the confirm action
    wire osa_keys_type press = osa_keys_type'(KEYS & ~key_q);
    wire hold_hit = KEYS.shift && !shift_fired && shift_cnt == HOLD_LAST;
    wire shift_tap = key_q.shift && !KEYS.shift && !shift_fired;
    wire confirm = press.enter || hold_hit;
    wire [3:0] cur_nib = edit_val[{digit, 2'h0} +: 4];
    wire [3:0] digit_mask = 4'h1 << digit;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            key_q <= '0;
        end else if (CE) begin
            key_q <= KEYS;
        end
    end

    // Shift hold timer; fires once per hold so a long hold is one confirm
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            shift_cnt <= '0;
            shift_fired <= 1'h0;
        end else if (CE) begin
            if (!KEYS.shift) begin
                shift_cnt <= '0;
                shift_fired <= 1'h0;
            end else if (hold_hit) begin
                shift_fired <= 1'h1;
            end else if (!shift_fired) begin
                shift_cnt <= shift_cnt + 1'h1;
            end
        end
    end

    // Blink phase for the edited digit and the save acknowledge
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            blink_cnt <= '0;
            blink_on <= 1'h0;
        end else if (CE) begin
            blink_cnt <= (blink_cnt == BLINK_LAST) ? '0 : blink_cnt + 1'h1;
            if (blink_cnt == BLINK_LAST) begin
                blink_on <= ~blink_on;
            end
        end
    end

    // Panel state machine
    always_comb begin
        next_state = state;
        next_pidx = pidx;
        next_digit = digit;
        next_edit = edit_val;
        next_midx = midx;
        store_en = 1'h0;
        unique case (state)
            OSA_ST_STATUS: begin
                if (press.mode_key) next_state = OSA_ST_PNUM;
            end
            OSA_ST_PNUM: begin
                if (press.mode_key) begin
                    next_state = OSA_ST_MNUM;
                end else if (confirm) begin
                    next_state = OSA_ST_EDIT;
                    next_edit = stored[pidx];
                    next_digit = 2'h0;
                end else if (press.up) begin
                    next_pidx = (pidx == `OSA_IDX_LAST) ? 2'h0 : pidx + 2'h1;
                end else if (press.down) begin
                    next_pidx = (pidx == 2'h0) ? `OSA_IDX_LAST : pidx - 2'h1;
                end
            end
            OSA_ST_EDIT: begin
                if (confirm) begin
                    store_en = 1'h1;
                    next_state = OSA_ST_SAVED;
                end else if (press.up) begin
                    next_edit[{digit, 2'h0} +: 4] = cur_nib + 4'h1;
                end else if (press.down) begin
                    next_edit[{digit, 2'h0} +: 4] = cur_nib - 4'h1;
                end else if (press.left || shift_tap) begin
                    next_digit = digit + 2'h1;
                end else if (press.right) begin
                    next_digit = digit - 2'h1;
                end
            end
            OSA_ST_SAVED: begin
                if (confirm) next_state = OSA_ST_PNUM;
            end
            OSA_ST_MNUM: begin
                if (press.mode_key) begin
                    next_state = OSA_ST_STATUS;
                end else if (confirm) begin
                    next_state = OSA_ST_MDATA;
                end else if (press.up) begin
                    next_midx = (midx == `OSA_MON_LAST) ? 2'h0 : midx + 2'h1;
                end else if (press.down) begin
                    next_midx = (midx == 2'h0) ? `OSA_MON_LAST : midx - 2'h1;
                end
            end
            OSA_ST_MDATA: begin
                if (confirm) next_state = OSA_ST_MNUM;
            end
            default: next_state = OSA_ST_STATUS;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state <= OSA_ST_STATUS;
            pidx <= `OSA_IDX_GROUP_A;
            digit <= 2'h0;
            edit_val <= 16'h0000;
            midx <= `OSA_MON_REF;
        end else if (CE) begin
            state <= next_state;
            pidx <= next_pidx;
            digit <= next_digit;
            edit_val <= next_edit;
            midx <= next_midx;
        end
    end

    // Nonvolatile parameter store: it survives reset, so it carries no reset
    always_ff @(posedge MCLK) begin
        if (CE) begin
            if (NV_INIT) begin
                stored[`OSA_IDX_GROUP_A] <= `OSA_DEF_GROUP_A;
                stored[`OSA_IDX_GROUP_B] <= `OSA_DEF_GROUP_B;
                stored[`OSA_IDX_GROUP_C] <= `OSA_DEF_GROUP_C;
                stored[`OSA_IDX_POLARITY] <= `OSA_DEF_POLARITY;
            end else if (store_en) begin
                stored[pidx] <= edit_val;
            end
        end
    end

    // Routing in force is copied from the store once after each power-up reset
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            active_alloc <= {`OSA_DEF_GROUP_C, `OSA_DEF_GROUP_B, `OSA_DEF_GROUP_A};
            active_pol <= `OSA_DEF_POLARITY;
            load_pending <= 1'h1;
        end else if (CE && load_pending && !NV_INIT) begin
            active_alloc <= {stored[`OSA_IDX_GROUP_C], stored[`OSA_IDX_GROUP_B],
                stored[`OSA_IDX_GROUP_A]};
            active_pol <= stored[`OSA_IDX_POLARITY];
            load_pending <= 1'h0;
        end
    end

    // Signals the control method does not detect are dropped before routing
    always_comb begin
        gated = STATUS_IN;
        gated.position_done = STATUS_IN.position_done
            && CONTROL_METHOD == OSA_M_POSITION;
        gated.speed_match = STATUS_IN.speed_match && CONTROL_METHOD == OSA_M_SPEED;
    end

    // Output circuits; the panel never touches their inputs, so monitoring is harmless
    genvar g;
    generate
        for (g = 0; g < `OSA_NUM_OUT; g++) begin : gen_out
            osa_out_cell #(
                .OUT_ID(4'(g + 1)),
                .NSIG(`OSA_NUM_SIG)
            ) u_cell (
                .clk(MCLK),
                .rst(RST),
                .ce(CE),
                .alloc(active_alloc[`OSA_NUM_SIG*4-1:0]),
                .status(gated),
                .polarity(active_pol[g*4]),
                .out(SEQ_OUT[g])
            );
        end
    endgenerate

    // Monitor items and display contents
    assign mon_value = (midx == `OSA_MON_REF) ? REF_VALUE :
        (midx == `OSA_MON_INPUTS) ? {8'h00, IN_STATE} :
        (midx == `OSA_MON_OUTPUTS) ? {13'h0000, SEQ_OUT} :
        {7'h00, gated};
    assign next_value = (next_state == OSA_ST_PNUM) ? {14'h0000, next_pidx} :
        (next_state == OSA_ST_EDIT || next_state == OSA_ST_SAVED) ? next_edit :
        (next_state == OSA_ST_MNUM) ? {14'h0000, next_midx} :
        (next_state == OSA_ST_MDATA) ? mon_value : {7'h00, gated};
    assign next_blank = !blink_on ? 4'h0 :
        (next_state == OSA_ST_EDIT) ? (4'h1 << next_digit) :
        (next_state == OSA_ST_SAVED) ? 4'hF : 4'h0;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            DISP_STATE <= OSA_ST_STATUS;
            DISP_VALUE <= 16'h0000;
            DISP_BLANK <= 4'h0;
        end else if (CE) begin
            DISP_STATE <= next_state;
            DISP_VALUE <= next_value;
            DISP_BLANK <= next_blank;
        end
    end

    AST_GATE_POS: assert property (@(posedge MCLK) disable iff (RST)
        CONTROL_METHOD != OSA_M_POSITION |-> !gated.position_done)
        else $error("Undetected positioning done reached the outputs");
    AST_GATE_SPD: assert property (@(posedge MCLK) disable iff (RST)
        CONTROL_METHOD != OSA_M_SPEED |-> !gated.speed_match)
        else $error("Undetected speed match reached the outputs");
    AST_ROUTING_FROZEN: assert property (@(posedge MCLK) disable iff (RST)
        !load_pending |=> $stable(active_alloc) && $stable(active_pol))
        else $error("Routing changed without a power-up reset");
    AST_MODE_ENTRY: assert property (@(posedge MCLK) disable iff (RST)
        CE && state == OSA_ST_STATUS && press.mode_key |=> state == OSA_ST_PNUM
            ##0 DISP_STATE == OSA_ST_PNUM)
        else $error("Mode key did not enter parameter mode");
    AST_DIGIT_BLINK: assert property (@(posedge MCLK) disable iff (RST)
        CE && next_state == OSA_ST_EDIT && blink_on
            |=> DISP_BLANK == digit_mask)
        else $error("Selected digit is not the one blinking");
    AST_HOLD_CONFIRM: assert property (@(posedge MCLK) disable iff (RST)
        confirm |-> press.enter || (KEYS.shift && shift_cnt == HOLD_LAST))
        else $error("Confirm without enter or a full shift hold");
    AST_SAVE: assert property (@(posedge MCLK) disable iff (RST)
        CE && !NV_INIT && state == OSA_ST_EDIT && confirm
            |=> state == OSA_ST_SAVED && stored[$past(pidx)] == $past(edit_val))
        else $error("Confirm did not store the edited value");
    AST_MON_VIEW: assert property (@(posedge MCLK) disable iff (RST)
        CE && next_state == OSA_ST_MDATA |=> DISP_VALUE == $past(mon_value))
        else $error("Monitor item not shown");

endmodule

// ==== core/osa_params.svh ====
// Constants of the output signal allocator: defaults, field layout and timing.
`ifndef OSA_PARAMS_SVH
`define OSA_PARAMS_SVH

// Clock rate and operator timing, in their own units
`define OSA_CLK_MHZ 200
`define OSA_HOLD_MS 1000
`define OSA_BLINK_MS 250

// Field layout: one nibble per status signal, fields packed as {group_c, group_b, group_a}
`define OSA_NIB_W 4
`define OSA_NUM_SIG 9
`define OSA_NUM_OUT 3
`define OSA_PAR_W 16
`define OSA_ALLOC_MAX 4'h3

// Parameter store indexes as stepped by the up and down keys
`define OSA_IDX_GROUP_A 2'h0
`define OSA_IDX_GROUP_B 2'h1
`define OSA_IDX_GROUP_C 2'h2
`define OSA_IDX_POLARITY 2'h3
`define OSA_IDX_LAST 2'h3

// Monitor items
`define OSA_MON_REF 2'h0
`define OSA_MON_INPUTS 2'h1
`define OSA_MON_OUTPUTS 2'h2
`define OSA_MON_STATUS 2'h3
`define OSA_MON_LAST 2'h3

// Factory values of the parameter store
`define OSA_DEF_GROUP_A 16'h3211
`define OSA_DEF_GROUP_B 16'h0000
`define OSA_DEF_GROUP_C 16'h0000
`define OSA_DEF_POLARITY 16'h0000

// Output level while nothing drives a circuit at the default polarity
`define OSA_OUT_IDLE 1'h1

`endif

// ==== core/osa_pkg.sv ====
// Types shared by the output signal allocator modules.
package osa_pkg;

    // Status signals; position_done is bit 0 so bit k pairs with nibble k of {c,b,a}
    typedef struct packed {
        logic near;
        logic warning;
        logic brake_interlock;
        logic speed_limit_hit;
        logic torque_limit_hit;
        logic servo_ready;
        logic rotation_detected;
        logic speed_match;
        logic position_done;
    } osa_status_type;

    // Front panel keys, levels, high while pressed
    typedef struct packed {
        logic mode_key;
        logic up;
        logic down;
        logic left;
        logic right;
        logic enter;
        logic shift;
    } osa_keys_type;

    // Control method of the drive
    typedef enum logic [1:0] {
        OSA_M_SPEED = 2'h0,
        OSA_M_POSITION = 2'h1,
        OSA_M_TORQUE = 2'h2
    } osa_method_type;

    // Panel states
    typedef enum logic [5:0] {
        OSA_ST_STATUS = 6'h01,
        OSA_ST_PNUM = 6'h02,
        OSA_ST_EDIT = 6'h04,
        OSA_ST_SAVED = 6'h08,
        OSA_ST_MNUM = 6'h10,
        OSA_ST_MDATA = 6'h20
    } osa_state_type;

endpackage

// ==== core/osa_out_cell.sv ====
// One sequence output circuit: OR of the signals allocated to it, with polarity.
`timescale 1ns/10ps
`include "osa_params.svh"

module osa_out_cell #(
    parameter logic [3:0] OUT_ID = 4'h1,
    parameter int NSIG = `OSA_NUM_SIG
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NSIG*4-1:0] alloc,
    input wire logic [NSIG-1:0] status,
    input wire logic polarity,
    output logic out
);

    initial begin
        if (OUT_ID == 4'h0 || OUT_ID > `OSA_ALLOC_MAX) begin
            $error("osa_out_cell: OUT_ID out of range");
        end
    end

    logic [NSIG-1:0] hit;
    wire hit_any = |hit;

    // A field of 0 or above the last circuit routes nowhere
    always_comb begin
        for (int k = 0; k < NSIG; k++) begin
            hit[k] = status[k] && (alloc[k*4 +: 4] == OUT_ID);
        end
    end

    // Active drives the polarity level, idle the opposite one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out <= `OSA_OUT_IDLE;
        end else if (ce) begin
            out <= hit_any ? polarity : ~polarity;
        end
    end

    AST_OR_ACTIVE: assert property (@(posedge clk) disable iff (rst)
        ce && hit_any |=> out == $past(polarity))
        else $error("Allocated active signal did not drive the output");
    AST_IDLE_LEVEL: assert property (@(posedge clk) disable iff (rst)
        ce && !hit_any |=> out == !$past(polarity))
        else $error("Output not at inactive level with nothing active");
    AST_ROUTE: assert property (@(posedge clk) disable iff (rst)
        ce && status[0] && alloc[3:0] == OUT_ID |=> out == $past(polarity))
        else $error("Field value did not route signal to its circuit");

endmodule

// ==== tb/osa_host_model.sv ====
// Host sequence controller model that reads the three sequence outputs.
`timescale 1ns/10ps

module osa_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] seq_out,
    input wire logic [2:0] pol,
    output logic [2:0] active
);
    // Decode each circuit by its polarity; a level-sampling host sees one cycle late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 3'h0;
        end else begin
            active <= ~(seq_out ^ pol);
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking testbench of the output signal allocator.
`timescale 1ns/10ps

module tb_top;
    import osa_pkg::*;
    localparam int BLINK = 4;
    localparam int K_MODE = 6;
    localparam int K_UP = 5;
    localparam int K_DOWN = 4;
    localparam int K_LEFT = 3;
    localparam int K_RIGHT = 2;
    localparam int K_ENTER = 1;
    localparam int K_SHIFT = 0;
    logic MCLK, RST, CE, NV_INIT;
    osa_status_type STATUS_IN;
    osa_method_type CONTROL_METHOD;
    osa_keys_type KEYS;
    logic [15:0] REF_VALUE;
    logic [7:0] IN_STATE;
    logic [2:0] SEQ_OUT, host_pol, host_act;
    osa_state_type DISP_STATE;
    logic [15:0] DISP_VALUE;
    logic [3:0] DISP_BLANK;
    int error_cnt = 0;
    int checks_done = 0;

    // Short counts keep the one-second hold and blink period cheap to simulate
    osa_top #(.HOLD_CYCLES(8), .BLINK_CYCLES(BLINK), .CNT_W(28)) uut (
        .MCLK(MCLK), .RST(RST), .CE(CE), .NV_INIT(NV_INIT), .STATUS_IN(STATUS_IN),
        .CONTROL_METHOD(CONTROL_METHOD), .KEYS(KEYS), .REF_VALUE(REF_VALUE),
        .IN_STATE(IN_STATE), .SEQ_OUT(SEQ_OUT), .DISP_STATE(DISP_STATE),
        .DISP_VALUE(DISP_VALUE), .DISP_BLANK(DISP_BLANK)
    );

    osa_host_model host (.clk(MCLK), .rst(RST), .seq_out(SEQ_OUT), .pol(host_pol),
        .active(host_act));

    // 200 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end

    task automatic finish_test;
        $display("Checks done %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Inputs move at falling edges; three rising edges let the registered answer land
    task automatic settle;
        repeat (3) @(negedge MCLK);
    endtask

    task automatic press(input int k);
        @(negedge MCLK);
        KEYS[k] = 1'b1;
        @(negedge MCLK);
        KEYS[k] = 1'b0;
        settle();
    endtask

    task automatic power_cycle;
        @(negedge MCLK);
        RST = 1'b1;
        repeat (2) @(negedge MCLK);
        RST = 1'b0;
        settle();
    endtask

    task automatic watch_blank(input string what, input logic [3:0] mask);
        logic seen;
        seen = 1'b0;
        repeat (4 * BLINK + 4) begin
            @(negedge MCLK);
            if (DISP_BLANK === mask) seen = 1'b1;
        end
        chk(what, 16'h0001, {15'h0, seen});
    endtask

    task automatic test_idle;
        settle();
        chk("idle outputs", 16'h0007, {13'h0, SEQ_OUT});
        chk("reset panel", 16'h0001, {10'h0, DISP_STATE});
    endtask

    task automatic test_routing;
        STATUS_IN.servo_ready = 1'b1;
        settle();
        chk("servo ready to third", 16'h0003, {13'h0, SEQ_OUT});
        STATUS_IN.rotation_detected = 1'b1;
        settle();
        chk("rotation to second", 16'h0001, {13'h0, SEQ_OUT});
        // Only the signals whose fields are all zero, in one assignment
        STATUS_IN = osa_status_type'(9'h1F0);
        settle();
        chk("unallocated signals", 16'h0007, {13'h0, SEQ_OUT});
        STATUS_IN = '0;
    endtask

    task automatic test_method;
        CONTROL_METHOD = OSA_M_SPEED;
        STATUS_IN.position_done = 1'b1;
        settle();
        chk("done in speed", 16'h0007, {13'h0, SEQ_OUT});
        STATUS_IN.speed_match = 1'b1;
        settle();
        chk("match in speed", 16'h0006, {13'h0, SEQ_OUT});
        CONTROL_METHOD = OSA_M_POSITION;
        settle();
        chk("done in position", 16'h0006, {13'h0, SEQ_OUT});
        STATUS_IN.position_done = 1'b0;
        settle();
        chk("match in position", 16'h0007, {13'h0, SEQ_OUT});
        CONTROL_METHOD = OSA_M_TORQUE;
        STATUS_IN.position_done = 1'b1;
        settle();
        chk("both in torque", 16'h0007, {13'h0, SEQ_OUT});
        STATUS_IN = '0;
    endtask

    // Route brake interlock to the second circuit beside rotation detection
    task automatic test_edit;
        press(K_MODE);
        chk("param state", 16'h0002, {10'h0, DISP_STATE});
        press(K_UP);
        chk("param index", 16'h0001, DISP_VALUE);
        press(K_ENTER);
        chk("edit state", 16'h0004, {10'h0, DISP_STATE});
        chk("edit value", 16'h0000, DISP_VALUE);
        press(K_LEFT);
        // A short shift tap moves the selection left like the left key
        press(K_SHIFT);
        watch_blank("tap moves digit", 4'h4);
        press(K_RIGHT);
        watch_blank("right moves digit", 4'h2);
        press(K_LEFT);
        watch_blank("digit blink", 4'h4);
        press(K_UP);
        press(K_UP);
        press(K_UP);
        press(K_DOWN);
        chk("edited value", 16'h0200, DISP_VALUE);
        // Operator holds shift past the hold time to confirm
        @(negedge MCLK);
        KEYS[K_SHIFT] = 1'b1;
        repeat (11) @(negedge MCLK);
        KEYS[K_SHIFT] = 1'b0;
        settle();
        chk("saved state", 16'h0008, {10'h0, DISP_STATE});
        watch_blank("save blink", 4'hF);
        press(K_ENTER);
        chk("back to number", 16'h0002, {10'h0, DISP_STATE});
        STATUS_IN.brake_interlock = 1'b1;
        settle();
        chk("before power cycle", 16'h0007, {13'h0, SEQ_OUT});
        power_cycle();
        chk("after power cycle", 16'h0005, {13'h0, SEQ_OUT});
        STATUS_IN.rotation_detected = 1'b1;
        settle();
        chk("two on second", 16'h0005, {13'h0, SEQ_OUT});
        STATUS_IN.brake_interlock = 1'b0;
        settle();
        chk("rotation alone", 16'h0005, {13'h0, SEQ_OUT});
        STATUS_IN = '0;
    endtask

    // Reverse the first circuit and observe it through the host
    task automatic test_polarity;
        press(K_MODE);
        repeat (3) press(K_UP);
        chk("polarity index", 16'h0003, DISP_VALUE);
        press(K_ENTER);
        press(K_UP);
        chk("polarity value", 16'h0001, DISP_VALUE);
        press(K_ENTER);
        press(K_ENTER);
        power_cycle();
        host_pol = 3'h1;
        settle();
        chk("reversed idle", 16'h0006, {13'h0, SEQ_OUT});
        chk("host idle", 16'h0000, {13'h0, host_act});
        CONTROL_METHOD = OSA_M_POSITION;
        STATUS_IN.position_done = 1'b1;
        settle();
        chk("reversed active", 16'h0007, {13'h0, SEQ_OUT});
        chk("host active", 16'h0001, {13'h0, host_act});
    endtask

    task automatic test_monitor;
        REF_VALUE = 16'hA5C3;
        IN_STATE = 8'h5A;
        press(K_MODE);
        press(K_MODE);
        chk("monitor state", 16'h0010, {10'h0, DISP_STATE});
        press(K_ENTER);
        chk("reference shown", 16'hA5C3, DISP_VALUE);
        press(K_ENTER);
        press(K_UP);
        press(K_ENTER);
        chk("inputs shown", 16'h005A, DISP_VALUE);
        press(K_ENTER);
        press(K_UP);
        press(K_ENTER);
        chk("outputs shown", 16'h0007, {13'h0, DISP_VALUE[2:0]});
        STATUS_IN.position_done = 1'b0;
        settle();
        chk("outputs in monitor", 16'h0006, {13'h0, SEQ_OUT});
        chk("outputs live", 16'h0006, {13'h0, DISP_VALUE[2:0]});
        // Internal status item shows the method-gated signals
        press(K_ENTER);
        press(K_UP);
        STATUS_IN = osa_status_type'(9'h003);
        press(K_ENTER);
        chk("status shown", 16'h0001, DISP_VALUE);
    endtask

    // Main sequence: store loaded with factory values during the first reset
    initial begin
        {RST, NV_INIT, CE} = 3'h7;
        STATUS_IN = '0;
        CONTROL_METHOD = OSA_M_SPEED;
        KEYS = '0;
        REF_VALUE = 16'h0000;
        IN_STATE = 8'h00;
        host_pol = 3'h0;
        repeat (3) @(negedge MCLK);
        NV_INIT = 1'b0;
        @(negedge MCLK);
        RST = 1'b0;
        test_idle();
        test_routing();
        test_method();
        test_edit();
        test_polarity();
        test_monitor();
        finish_test();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
endmodule
